//--- pmoc_pkg.sv
package pmoc_pkg;

  // subcommand codes sent by the initiating unit
  localparam logic [7:0] PMOC_SC_SIMPLE = 8'h01;
  localparam logic [7:0] PMOC_SC_L2 = 8'h02;
  localparam logic [7:0] PMOC_SC_TRIM = 8'h03;

  // response codes sent by the responding unit
  localparam logic [7:0] PMOC_RC_GRANT = 8'h80;
  localparam logic [7:0] PMOC_RC_REJECT = 8'h81;
  localparam logic [7:0] PMOC_RC_L2_GRANT = 8'h82;
  localparam logic [7:0] PMOC_RC_L2_REJECT = 8'h83;
  localparam logic [7:0] PMOC_RC_TRIM_GRANT = 8'h84;
  localparam logic [7:0] PMOC_RC_TRIM_REJECT = 8'h85;

  // reason codes carried by the three reject responses
  localparam logic [7:0] PMOC_RS_BUSY = 8'h01;
  localparam logic [7:0] PMOC_RS_INVALID = 8'h02;
  localparam logic [7:0] PMOC_RS_NOT_DESIRED = 8'h03;
  localparam logic [7:0] PMOC_RS_INFEASIBLE = 8'h04;

  // proposed link state encodings
  localparam logic [7:0] PMOC_ST_FULL = 8'h00;
  localparam logic [7:0] PMOC_ST_IDLE = 8'h03;

  // downstream power cutback ceiling, 40 dB in 1 dB steps
  localparam logic [7:0] PMOC_PCB_MAX_DB = 8'h28;

  // message lengths in octets
  localparam logic [9:0] PMOC_LEN_SHORT = 10'h003;
  localparam logic [9:0] PMOC_LEN_GRANT = 10'h002;
  localparam logic [9:0] PMOC_LEN_L2_REQ = 10'h004;
  localparam logic [9:0] PMOC_LEN_L2_GRANT = 10'h006;

  // octet positions inside a message
  localparam logic [9:0] PMOC_OFS_DSG = 10'h000;
  localparam logic [9:0] PMOC_OFS_CODE = 10'h001;
  localparam logic [9:0] PMOC_OFS_P0 = 10'h002;
  localparam logic [9:0] PMOC_OFS_P1 = 10'h003;
  localparam logic [9:0] PMOC_OFS_L2_TBL = 10'h004;
  localparam logic [9:0] PMOC_OFS_GR_CAR = 10'h006;

  // local request kinds
  typedef enum logic [1:0] {
    PMOC_KIND_NONE = 2'h0,
    PMOC_KIND_SIMPLE = 2'h1,
    PMOC_KIND_L2 = 2'h2,
    PMOC_KIND_TRIM = 2'h3
  } pmoc_kind_t;

  // transmit sequencer states
  typedef enum logic [3:0] {
    PMOC_IDLE = 4'b0001,
    PMOC_LOAD = 4'b0010,
    PMOC_WAIT = 4'b0100,
    PMOC_SEND = 4'b1000
  } pmoc_state_t;

  // total octets of a message; zero marks a reserved code
  function automatic logic [9:0] pmoc_msg_len(input logic [7:0] code,
                                              input logic [2:0] nlp,
                                              input logic [7:0] nf);
    case (code)
      PMOC_SC_SIMPLE, PMOC_SC_TRIM, PMOC_RC_REJECT, PMOC_RC_L2_REJECT,
      PMOC_RC_TRIM_GRANT, PMOC_RC_TRIM_REJECT: pmoc_msg_len = PMOC_LEN_SHORT;
      PMOC_RC_GRANT: pmoc_msg_len = PMOC_LEN_GRANT;
      PMOC_SC_L2: pmoc_msg_len = PMOC_LEN_L2_REQ + 10'({nlp, 2'b00});
      PMOC_RC_L2_GRANT: pmoc_msg_len = PMOC_LEN_L2_GRANT
        + 10'({nlp, 1'b0}) + 10'({nf, 1'b0}) + 10'(nf);
      default: pmoc_msg_len = 10'h000;
    endcase
  endfunction

  // cutback lies between the initialisation floor and 40 dB
  function automatic logic pmoc_pcb_ok(input logic [7:0] v,
                                       input logic [7:0] floor_db);
    pmoc_pcb_ok = (v >= floor_db) && (v <= PMOC_PCB_MAX_DB);
  endfunction

endpackage

//--- pmoc_body_mem.sv
`timescale 1ns/1ps
// octet table for path frame bits and subcarrier fields
module pmoc_body_mem #(
  parameter int AW = 10
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [0:(1<<AW)-1];
  logic [7:0] rd_q;

  // storage write and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_q <= mem_q[rd_addr];
  end

  assign rd_data = rd_q;
endmodule // pmoc_body_mem

//--- pmoc_rx_parse.sv
`timescale 1ns/1ps
// splits a received frame into code and parameters, checks its length
module pmoc_rx_parse import pmoc_pkg::*; #(
  parameter logic [7:0] DESIG = 8'h07
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // configuration
  input wire logic [2:0] enabled_path_count,
  // received octets
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  // parsed frame
  output logic done,
  output logic ok,
  output logic [7:0] code,
  output logic [7:0] p0,
  output logic [7:0] p1
);
  logic [9:0] idx_q, idx_d;
  logic [7:0] code_q, code_d, p0_q, p0_d, p1_q, p1_d, nf_q, nf_d;
  logic dsg_q, dsg_d, done_q, done_d, ok_q, ok_d;
  logic [9:0] n2;
  logic [7:0] code_now, nf_now;

  // next-state capture of each field by position
  always_comb begin
    idx_d = idx_q;
    code_d = code_q;
    p0_d = p0_q;
    p1_d = p1_q;
    nf_d = nf_q;
    dsg_d = dsg_q;
    done_d = 1'b0;
    ok_d = 1'b0;
    n2 = 10'({enabled_path_count, 1'b0});
    code_now = (idx_q == PMOC_OFS_CODE) ? rx_data : code_q;
    nf_now = (idx_q == n2 + 10'h005) ? rx_data : nf_q;
    if (rx_valid) begin
      if (idx_q == PMOC_OFS_DSG) begin
        dsg_d = (rx_data == DESIG);
      end
      if (idx_q == PMOC_OFS_CODE) begin
        code_d = rx_data;
      end
      // grant fields sit behind the per-path frame bits
      if (code_now == PMOC_RC_L2_GRANT) begin
        if (idx_q == n2 + 10'h002) p0_d = rx_data;
        if (idx_q == n2 + 10'h003) p1_d = rx_data;
        if (idx_q == n2 + 10'h005) nf_d = rx_data;
      end else begin
        if (idx_q == PMOC_OFS_P0) p0_d = rx_data;
        if (idx_q == PMOC_OFS_P1) p1_d = rx_data;
      end
      if (idx_q != 10'h3FF) begin
        idx_d = idx_q + 10'h001;
      end
      if (rx_last) begin
        done_d = 1'b1;
        ok_d = dsg_d && (idx_q + 10'h001 ==
          pmoc_msg_len(code_now, enabled_path_count, nf_now));
        idx_d = 10'h000;
        nf_d = 8'h00;
      end
    end
  end

  // field registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= 10'h000;
      code_q <= 8'h00;
      p0_q <= 8'h00;
      p1_q <= 8'h00;
      nf_q <= 8'h00;
      dsg_q <= 1'b0;
      done_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      code_q <= code_d;
      p0_q <= p0_d;
      p1_q <= p1_d;
      nf_q <= nf_d;
      dsg_q <= dsg_d;
      done_q <= done_d;
      ok_q <= ok_d;
    end
  end

  assign done = done_q;
  assign ok = ok_q;
  assign code = code_q;
  assign p0 = p0_q;
  assign p1 = p1_q;
endmodule // pmoc_rx_parse

//--- pmoc_top.sv
// Overview of operation
// - either unit may propose a link state change; the other must answer.
// - every message starts with the designator, subcommand, then parameters.
// - a response carries its grant or reject code in the second octet.
// - messages travel in the channel's octet framing and request protocol.
// - simple request is three octets, code 01, then proposed link state.
// - low power entry request uses code 02, length four plus four per path.
// - entry request holds min cutback, max cutback, max then min frame bits.
// - trim request is three octets, code 03, then new cutback in dB.
// - grant is two octets, code 80; reject is code 81 plus reason.
// - entry grant code 82, six plus two per path plus three per carrier.
// - entry grant then has actual cutback, exit cutback, table flag, count.
// - entry grant ends with three subcarrier octets per counted carrier.
// - entry reject is three octets, code 83, then one reason octet.
// - trim grant is three octets, code 84, then exit symbol cutback.
// - trim reject is three octets, code 85, then one reason octet.
// - undefined subcommand and response codes are never sent.
// - cutback octets give absolute cutback from 0 to 40 dB per dB.
// - requested minimum and maximum cutbacks are absolute, not offsets.
// - no cutback below the initialisation value or above 40 dB is encoded.
// - reasons busy 01, invalid 02, not desired 03, infeasible 04.
// - full power state is 00, idle 03; others get an invalid reject.
`timescale 1ns/1ps
module pmoc_top import pmoc_pkg::*; #(
  parameter logic [7:0] DESIG = 8'h07,
  parameter int AW = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // line configuration
  input wire logic [2:0] enabled_path_count,
  input wire logic [7:0] init_cutback,
  // received octets
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  // transmitted octets
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  // local request
  input wire logic req_start,
  input wire logic [1:0] req_kind,
  input wire logic [7:0] req_state,
  input wire logic [7:0] req_min_cutback,
  input wire logic [7:0] req_max_cutback,
  input wire logic [7:0] req_trim_cutback,
  output logic ready,
  output logic req_refused,
  // responder policy and grant fields
  input wire logic resp_busy,
  input wire logic resp_not_desired,
  input wire logic resp_infeasible,
  input wire logic [7:0] grant_cutback,
  input wire logic [7:0] exit_cutback,
  input wire logic [7:0] exit_table_flag,
  input wire logic [7:0] grant_carriers,
  // octet table load
  input wire logic tbl_wr,
  input wire logic [AW-1:0] tbl_addr,
  input wire logic [7:0] tbl_data,
  // received message indication
  output logic ind_valid,
  output logic ind_err,
  output logic [7:0] ind_code,
  output logic [7:0] ind_p0,
  output logic [7:0] ind_p1
);
  pmoc_state_t st_q, st_d;
  logic [9:0] idx_q, idx_d, len_q, len_d, n2;
  logic [7:0] mcode_q, mcode_d, f0_q, f0_d, f1_q, f1_d, f2_q, f2_d;
  logic [7:0] f3_q, f3_d;
  logic [2:0] nlp_q, nlp_d;
  logic tx_valid_q, tx_valid_d, tx_last_q, tx_last_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic pend_q, pend_d, ready_q, ready_d, refused_q, refused_d;
  logic [7:0] rcode_q, rcode_d, rf0_q, rf0_d, rf1_q, rf1_d;
  logic [7:0] rf2_q, rf2_d, rf3_q, rf3_d;
  logic ind_valid_q, ind_valid_d, ind_err_q, ind_err_d;
  logic [7:0] ind_code_q, ind_code_d, ind_p0_q, ind_p0_d, ind_p1_q;
  logic [7:0] ind_p1_d;
  logic oct_mem, oct_last, req_ok;
  logic [7:0] oct_val, req_code, req_f0, req_f1, rd_data;
  logic [AW-1:0] oct_addr;
  logic p_done, p_ok;
  logic [7:0] p_code, p_p0, p_p1;

  // frame parser on the receive side
  pmoc_rx_parse #(.DESIG(DESIG)) u_parse (
    .clk(clk),
    .nrst(nrst),
    .enabled_path_count(enabled_path_count),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_last(rx_last),
    .done(p_done),
    .ok(p_ok),
    .code(p_code),
    .p0(p_p0),
    .p1(p_p1)
  );

  // path frame bits and subcarrier octets for outgoing messages
  pmoc_body_mem #(.AW(AW)) u_mem (
    .clk(clk),
    .wr_en(tbl_wr),
    .wr_addr(tbl_addr),
    .wr_data(tbl_data),
    .rd_addr(oct_addr),
    .rd_data(rd_data)
  );

  // source of the octet at the current position
  always_comb begin
    oct_mem = 1'b0;
    oct_addr = '0;
    oct_val = f0_q;
    n2 = 10'({nlp_q, 1'b0});
    oct_last = (idx_q == len_q - 10'h001);
    if (idx_q == PMOC_OFS_DSG) begin
      oct_val = DESIG;
    end else if (idx_q == PMOC_OFS_CODE) begin
      oct_val = mcode_q;
    end else if (mcode_q == PMOC_SC_L2) begin
      // min, max, then max and min frame bits per path
      if (idx_q == PMOC_OFS_P0) oct_val = f0_q;
      else if (idx_q == PMOC_OFS_P1) oct_val = f1_q;
      else begin
        oct_mem = 1'b1;
        oct_addr = AW'(idx_q - PMOC_OFS_L2_TBL);
      end
    end else if (mcode_q == PMOC_RC_L2_GRANT) begin
      if (idx_q < n2 + PMOC_OFS_P0) begin
        oct_mem = 1'b1;
        oct_addr = AW'(idx_q - PMOC_OFS_P0);
      end else if (idx_q == n2 + 10'h002) oct_val = f0_q;
      else if (idx_q == n2 + 10'h003) oct_val = f1_q;
      else if (idx_q == n2 + 10'h004) oct_val = f2_q;
      else if (idx_q == n2 + 10'h005) oct_val = f3_q;
      else begin
        oct_mem = 1'b1;
        oct_addr = AW'(idx_q - PMOC_OFS_GR_CAR);
      end
    end
  end

  // local request formatting and cutback checks
  always_comb begin
    req_code = PMOC_SC_SIMPLE;
    req_f0 = req_state;
    req_f1 = 8'h00;
    req_ok = 1'b0;
    case (req_kind)
      PMOC_KIND_SIMPLE: begin
        req_ok = (req_state == PMOC_ST_FULL) ||
                 (req_state == PMOC_ST_IDLE);
      end
      PMOC_KIND_L2: begin
        req_code = PMOC_SC_L2;
        req_f0 = req_min_cutback;
        req_f1 = req_max_cutback;
        req_ok = pmoc_pcb_ok(req_min_cutback, init_cutback) &&
                 pmoc_pcb_ok(req_max_cutback, init_cutback) &&
                 (req_min_cutback <= req_max_cutback);
      end
      PMOC_KIND_TRIM: begin
        req_code = PMOC_SC_TRIM;
        req_f0 = req_trim_cutback;
        req_ok = pmoc_pcb_ok(req_trim_cutback, init_cutback);
      end
      default: req_ok = 1'b0;
    endcase
  end

  // transmit sequencer, response decision and indications
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    len_d = len_q;
    mcode_d = mcode_q;
    f0_d = f0_q;
    f1_d = f1_q;
    f2_d = f2_q;
    f3_d = f3_q;
    nlp_d = nlp_q;
    tx_valid_d = tx_valid_q;
    tx_data_d = tx_data_q;
    tx_last_d = tx_last_q;
    pend_d = pend_q;
    rcode_d = rcode_q;
    rf0_d = rf0_q;
    rf1_d = rf1_q;
    rf2_d = rf2_q;
    rf3_d = rf3_q;
    refused_d = 1'b0;
    case (st_q)
      PMOC_IDLE: begin
        if (pend_q) begin
          // a pending answer goes out before any local request
          mcode_d = rcode_q;
          f0_d = rf0_q;
          f1_d = rf1_q;
          f2_d = rf2_q;
          f3_d = rf3_q;
          len_d = pmoc_msg_len(rcode_q, enabled_path_count, rf3_q);
          nlp_d = enabled_path_count;
          pend_d = 1'b0;
          idx_d = 10'h000;
          st_d = PMOC_LOAD;
        end else if (req_start && ready_q) begin
          if (req_ok) begin
            mcode_d = req_code;
            f0_d = req_f0;
            f1_d = req_f1;
            f2_d = 8'h00;
            f3_d = 8'h00;
            len_d = pmoc_msg_len(req_code, enabled_path_count, 8'h00);
            nlp_d = enabled_path_count;
            idx_d = 10'h000;
            st_d = PMOC_LOAD;
          end else begin
            refused_d = 1'b1;
          end
        end
      end
      PMOC_LOAD: begin
        if (oct_mem) begin
          st_d = PMOC_WAIT;
        end else begin
          tx_valid_d = 1'b1;
          tx_data_d = oct_val;
          tx_last_d = oct_last;
          st_d = PMOC_SEND;
        end
      end
      PMOC_WAIT: begin
        tx_valid_d = 1'b1;
        tx_data_d = rd_data;
        tx_last_d = oct_last;
        st_d = PMOC_SEND;
      end
      PMOC_SEND: begin
        // octet stands until the channel framer takes it
        if (tx_ready) begin
          tx_valid_d = 1'b0;
          tx_last_d = 1'b0;
          if (oct_last) begin
            st_d = PMOC_IDLE;
          end else begin
            idx_d = idx_q + 10'h001;
            st_d = PMOC_LOAD;
          end
        end
      end
      default: st_d = PMOC_IDLE;
    endcase
    // answer each well-formed request from the far unit
    if (p_done && p_ok) begin
      rf0_d = 8'h00;
      rf1_d = 8'h00;
      rf2_d = 8'h00;
      rf3_d = 8'h00;
      case (p_code)
        PMOC_SC_SIMPLE: begin
          pend_d = 1'b1;
          rcode_d = PMOC_RC_REJECT;
          if (p_p0 == PMOC_ST_FULL) begin
            rcode_d = PMOC_RC_GRANT;
          end else if (p_p0 != PMOC_ST_IDLE) begin
            rf0_d = PMOC_RS_INVALID;
          end else if (resp_busy) begin
            rf0_d = PMOC_RS_BUSY;
          end else if (resp_not_desired) begin
            rf0_d = PMOC_RS_NOT_DESIRED;
          end else begin
            rcode_d = PMOC_RC_GRANT;
          end
        end
        PMOC_SC_L2: begin
          pend_d = 1'b1;
          rcode_d = PMOC_RC_L2_REJECT;
          if (!pmoc_pcb_ok(p_p0, init_cutback) ||
              !pmoc_pcb_ok(p_p1, init_cutback) || (p_p0 > p_p1)) begin
            rf0_d = PMOC_RS_INVALID;
          end else if (resp_busy) begin
            rf0_d = PMOC_RS_BUSY;
          end else if (resp_infeasible ||
                       !pmoc_pcb_ok(exit_cutback, init_cutback) ||
                       (grant_cutback < p_p0) ||
                       (grant_cutback > p_p1)) begin
            rf0_d = PMOC_RS_INFEASIBLE;
          end else begin
            rcode_d = PMOC_RC_L2_GRANT;
            rf0_d = grant_cutback;
            rf1_d = exit_cutback;
            rf2_d = exit_table_flag;
            rf3_d = grant_carriers;
          end
        end
        PMOC_SC_TRIM: begin
          pend_d = 1'b1;
          rcode_d = PMOC_RC_TRIM_REJECT;
          if (!pmoc_pcb_ok(p_p0, init_cutback)) begin
            rf0_d = PMOC_RS_INVALID;
          end else if (resp_infeasible ||
                       !pmoc_pcb_ok(exit_cutback, init_cutback)) begin
            rf0_d = PMOC_RS_INFEASIBLE;
          end else begin
            rcode_d = PMOC_RC_TRIM_GRANT;
            rf0_d = exit_cutback;
          end
        end
        default: pend_d = pend_d; // responses are only reported
      endcase
    end
    ready_d = (st_d == PMOC_IDLE) && !pend_d && !refused_d;
    ind_valid_d = p_done && p_ok;
    ind_err_d = p_done && !p_ok;
    ind_code_d = p_done ? p_code : ind_code_q;
    ind_p0_d = p_done ? p_p0 : ind_p0_q;
    ind_p1_d = p_done ? p_p1 : ind_p1_q;
  end

  // state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= PMOC_IDLE;
      idx_q <= 10'h000;
      len_q <= 10'h000;
      mcode_q <= 8'h00;
      f0_q <= 8'h00;
      f1_q <= 8'h00;
      f2_q <= 8'h00;
      f3_q <= 8'h00;
      nlp_q <= 3'h0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
      pend_q <= 1'b0;
      ready_q <= 1'b0;
      refused_q <= 1'b0;
      rcode_q <= 8'h00;
      rf0_q <= 8'h00;
      rf1_q <= 8'h00;
      rf2_q <= 8'h00;
      rf3_q <= 8'h00;
      ind_valid_q <= 1'b0;
      ind_err_q <= 1'b0;
      ind_code_q <= 8'h00;
      ind_p0_q <= 8'h00;
      ind_p1_q <= 8'h00;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      len_q <= len_d;
      mcode_q <= mcode_d;
      f0_q <= f0_d;
      f1_q <= f1_d;
      f2_q <= f2_d;
      f3_q <= f3_d;
      nlp_q <= nlp_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
      tx_last_q <= tx_last_d;
      pend_q <= pend_d;
      ready_q <= ready_d;
      refused_q <= refused_d;
      rcode_q <= rcode_d;
      rf0_q <= rf0_d;
      rf1_q <= rf1_d;
      rf2_q <= rf2_d;
      rf3_q <= rf3_d;
      ind_valid_q <= ind_valid_d;
      ind_err_q <= ind_err_d;
      ind_code_q <= ind_code_d;
      ind_p0_q <= ind_p0_d;
      ind_p1_q <= ind_p1_d;
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_last = tx_last_q;
  assign ready = ready_q;
  assign req_refused = refused_q;
  assign ind_valid = ind_valid_q;
  assign ind_err = ind_err_q;
  assign ind_code = ind_code_q;
  assign ind_p0 = ind_p0_q;
  assign ind_p1 = ind_p1_q;

  // checks on the transmit stream and the answers
  tx_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q))
    else $error("octet changed while stalled");
  tx_lead_a: assert property (@(posedge clk) disable iff (!nrst)
    tx_valid_q && idx_q == PMOC_OFS_DSG |-> tx_data_q == DESIG)
    else $error("message does not open with designator");
  tx_code_a: assert property (@(posedge clk) disable iff (!nrst)
    tx_valid_q && idx_q == PMOC_OFS_CODE |->
      pmoc_msg_len(tx_data_q, nlp_q, f3_q) == len_q && len_q != 10'h000)
    else $error("reserved code or wrong length sent");
  tx_end_a: assert property (@(posedge clk) disable iff (!nrst)
    tx_valid_q && tx_last_q |-> idx_q + 10'h001 == len_q)
    else $error("message ended at wrong octet");
  tx_trim_a: assert property (@(posedge clk) disable iff (!nrst)
    tx_valid_q && idx_q == PMOC_OFS_P0 && mcode_q == PMOC_SC_TRIM |->
      pmoc_pcb_ok(tx_data_q, init_cutback))
    else $error("trim cutback out of range");
  full_grant_a: assert property (@(posedge clk) disable iff (!nrst)
    p_done && p_ok && p_code == PMOC_SC_SIMPLE && p_p0 == PMOC_ST_FULL
      |=> pend_q && rcode_q == PMOC_RC_GRANT)
    else $error("full power request not granted");
  bad_state_a: assert property (@(posedge clk) disable iff (!nrst)
    p_done && p_ok && p_code == PMOC_SC_SIMPLE && p_p0 != PMOC_ST_FULL &&
      p_p0 != PMOC_ST_IDLE
      |=> rcode_q == PMOC_RC_REJECT && rf0_q == PMOC_RS_INVALID)
    else $error("bad link state not rejected as invalid");
  req_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
    st_q == PMOC_IDLE && !pend_q && ready_q && req_start && !req_ok
      |=> refused_q && st_q == PMOC_IDLE ##1 !refused_q)
    else $error("bad request not refused");
endmodule // pmoc_top

//--- pmoc_far_end.sv
`timescale 1ns/1ps
// far-end unit: sends framed octets, takes replies with stalls
module pmoc_far_end (
  // clock
  input wire logic clk,
  // octets towards the block
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  // octets from the block
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  logic [7:0] got[$];
  // idle line at time zero
  initial begin
    rx_valid = 1'h0;
    rx_data = 8'h00;
    rx_last = 1'h0;
    tx_ready = 1'h0;
  end
  // accept on every other cycle so the sender must hold
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= #1 ~tx_ready;
  end
  // one whole message, last octet flagged, line scrambled after
  task automatic send(input logic [7:0] m[$]);
    foreach (m[i]) begin
      @(posedge clk);
      #1 rx_valid = 1'h1;
      rx_data = m[i];
      rx_last = (i == m.size() - 1);
    end
    @(posedge clk);
    #1 rx_valid = 1'h0;
    rx_last = 1'h0;
    rx_data = ~rx_data;
  endtask
endmodule  // pmoc_far_end

//--- power_mgmt_overhead_commands_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH %0t %h %h", $time, (a), (b)); end end
module power_mgmt_overhead_commands_bench import pmoc_pkg::*;;
  localparam logic [7:0] D = 8'h07;
  logic clk, nrst, req_start, busy, nd, inf, ready, req_refused;
  logic rx_valid, rx_last, tx_ready, tx_valid, tx_last, ind_valid, ind_err;
  logic tbl_wr;
  logic [1:0] req_kind;
  logic [9:0] tbl_addr;
  logic [7:0] v, fld, rx_data, tx_data, ind_code, ind_p0, ind_p1, tbl_data;
  int fails, num_checks, cyc;
  // block under test: one path, 2 dB floor
  pmoc_top #(.DESIG(D)) i_dut (.clk, .nrst, .enabled_path_count(3'h1),
    .init_cutback(8'h02), .rx_valid, .rx_data, .rx_last, .tx_ready,
    .tx_valid, .tx_data, .tx_last, .req_start, .req_kind, .req_state(v),
    .req_min_cutback(fld), .req_max_cutback(fld), .req_trim_cutback(v),
    .ready, .req_refused, .resp_busy(busy), .resp_not_desired(nd),
    .resp_infeasible(inf), .grant_cutback(fld), .exit_cutback(fld),
    .exit_table_flag(fld), .grant_carriers(fld), .tbl_wr,
    .tbl_addr, .tbl_data, .ind_valid, .ind_err, .ind_code, .ind_p0,
    .ind_p1);
  pmoc_far_end i_far (.clk, .rx_valid, .rx_data, .rx_last, .tx_ready,
    .tx_valid, .tx_data, .tx_last);
  // verdict and end of run
  task automatic finish_test();
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one settled clock step
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // wait for a whole reply and compare octet by octet
  task automatic exp_msg(input logic [7:0] e[$]);
    for (int i = 0; i < 300 && i_far.got.size() < e.size(); i++) tick();
    `CHK(i_far.got.size(), e.size())
    foreach (e[i]) `CHK(i_far.got[i], e[i])
    i_far.got.delete();
  endtask
  // received frame indication
  task automatic rx_ind(input logic err, input logic [7:0] c);
    for (int i = 0; i < 8 && !(ind_valid === 1'h1 || ind_err === 1'h1); i++)
      tick();
    `CHK(ind_err, err)
    if (!err) `CHK(ind_code, c)
  endtask
  // far-end request and the answer it must get
  task automatic far(input logic [7:0] m[$], input logic [7:0] e[$]);
    i_far.send(m);
    rx_ind(1'h0, m[1]);
    exp_msg(e);
  endtask
  // local request once ready
  task automatic local_req(input logic [1:0] k, input logic [7:0] val);
    for (int i = 0; i < 300 && ready !== 1'h1; i++) tick();
    req_kind = k;
    v = val;
    req_start = 1'h1;
    tick();
    req_start = 1'h0;
  endtask
  // refused local request sends nothing
  task automatic refused_chk();
    for (int i = 0; i < 4 && req_refused !== 1'h1; i++) tick();
    `CHK(req_refused, 1'h1)
    repeat (12) tick();
    `CHK(i_far.got.size(), 0)
  endtask
  task automatic t_simple();
    busy = 1'h1;
    far({D, 8'h01, 8'h03}, {D, 8'h81, 8'h01});
    busy = 1'h0;
    nd = 1'h1;
    far({D, 8'h01, 8'h03}, {D, 8'h81, 8'h03});
    far({D, 8'h01, 8'h00}, {D, 8'h80});
    far({D, 8'h01, 8'h05}, {D, 8'h81, 8'h02});
  endtask
  task automatic t_trim();
    inf = 1'h1;
    far({D, 8'h03, 8'h0A}, {D, 8'h85, 8'h04});
    inf = 1'h0;
    far({D, 8'h03, 8'h29}, {D, 8'h85, 8'h02});
    far({D, 8'h03, 8'h01}, {D, 8'h85, 8'h02});
    far({D, 8'h03, 8'h28}, {D, 8'h84, fld});
    busy = 1'h1;
    far({D, 8'h02, 8'h05, 8'h10, 8'h00, 8'h10, 8'h00, 8'h08},
      {D, 8'h83, 8'h01});
    busy = 1'h0;
  endtask
  // entry grant and local entry request, both built around the octet table
  task automatic t_l2();
    logic [7:0] e[$];
    for (int i = 0; i < 32; i++) begin
      tbl_wr = 1'h1;
      tbl_addr = 10'(i);
      tbl_data = 8'h40 + 8'(i);
      tick();
    end
    tbl_wr = 1'h0;
    e = {D, 8'h82, 8'h40, 8'h41, fld, fld, fld, fld};
    for (int i = 2; i < 32; i++) e.push_back(8'h40 + 8'(i));
    far({D, 8'h02, 8'h05, 8'h10, 8'h00, 8'h10, 8'h00, 8'h08}, e);
    local_req(2'h2, 8'h00);
    exp_msg({D, 8'h02, fld, fld, 8'h40, 8'h41, 8'h42, 8'h43});
  endtask
  task automatic t_local();
    local_req(2'h3, 8'h28);
    exp_msg({D, 8'h03, 8'h28});
    local_req(2'h1, 8'h03);
    exp_msg({D, 8'h01, 8'h03});
    local_req(2'h3, 8'h29);
    refused_chk();
    local_req(2'h0, 8'h00);
    refused_chk();
  endtask
  task automatic t_rx();
    i_far.send({D, 8'h80});
    rx_ind(1'h0, 8'h80);
    i_far.send({D, 8'h82, 8'h01, 8'h02, 8'h0B, 8'h0C, 8'h00, 8'h01, 8'h11,
      8'h12, 8'h13});
    rx_ind(1'h0, 8'h82);
    `CHK(ind_p0, 8'h0B)
    `CHK(ind_p1, 8'h0C)
    i_far.send({D, 8'h86, 8'h01});
    rx_ind(1'h1, 8'h00);
    i_far.send({8'h08, 8'h80});
    rx_ind(1'h1, 8'h00);
  endtask
  // 125 MHz clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // run limit well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // reset, then the scenarios
  initial begin
    nrst = 1'h0;
    req_start = 1'h0;
    req_kind = 2'h0;
    v = 8'h00;
    fld = 8'h0A;
    busy = 1'h0;
    nd = 1'h0;
    inf = 1'h0;
    tbl_wr = 1'h0;
    tbl_addr = 10'h000;
    tbl_data = 8'h00;
    repeat (8) tick();
    nrst = 1'h1;
    t_simple();
    t_trim();
    t_l2();
    t_local();
    t_rx();
    finish_test();
  end
endmodule  // power_mgmt_overhead_commands_bench
